// ---- rtl/pio_regs.svh ----
// constants for the parallel port block: widths and reset values
//----------------------------------------------------------------
// How it works
//----------------------------------------------------------------
// How it works
// - 39 bidirectional, 4 input, 8 open-drain bits
// - ports 0,1,2,3,6: direction 1 drives pin
// - port 4 bits 0-3 bidirectional by direction
// - port 4 bits 4-7 read pins only
// - port 5 only pulls low or releases
// - port 5 digital only when analog off
// - port 5 has no direction register
// - port 3 bits 15-12 hold nothing
// - port 6 bit 7 holds nothing
// - port 4 bits 7-4 no direction, read-only
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

`define PIO_BUS_W    16
`define PIO_W0       8
`define PIO_W1       4
`define PIO_W2       4
`define PIO_W3       12
`define PIO_W4L      4
`define PIO_W4H      4
`define PIO_W5       8
`define PIO_W6       7
`define PIO_DATA_RST 16'h0000
`define PIO_DIR_RST  16'h0000

`endif

// ---- rtl/pio_pkg.sv ----
// types shared by the parallel port block
package pio_pkg;

    //----------------------------------------------------------------
    // port selection on the cpu side
    //----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_P0 = 3'h0,
        SEL_P1 = 3'h1,
        SEL_P2 = 3'h2,
        SEL_P3 = 3'h3,
        SEL_P4 = 3'h4,
        SEL_P5 = 3'h5,
        SEL_P6 = 3'h6,
        SEL_NONE = 3'h7
    } port_sel_t;

endpackage : pio_pkg

// ---- rtl/pio_port.sv ----
// one bidirectional port: data and direction storage, pin synchroniser
`include "pio_regs.svh"
module pio_port #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         wr_data,
    input  wire logic         wr_dir,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe,
    output logic      [W-1:0] rd_val
);

    logic [W-1:0] data_r;
    logic [W-1:0] data_nxt;
    logic [W-1:0] dir_r;
    logic [W-1:0] dir_nxt;
    logic [W-1:0] sync1_r;
    logic [W-1:0] sync2_r;

    //----------------------------------------------------------------
    // storage
    //----------------------------------------------------------------
    // next values of data and direction
    always_comb begin
        data_nxt = data_r;
        dir_nxt  = dir_r;
        if (wr_data) begin
            data_nxt = wdata;
        end
        if (wr_dir) begin
            dir_nxt = wdata;
        end
    end

    // register data, direction and pin sampling
    always_ff @(posedge clk) begin
        if (srst) begin
            data_r  <= W'(`PIO_DATA_RST);
            dir_r   <= W'(`PIO_DIR_RST);
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            data_r  <= data_nxt;
            dir_r   <= dir_nxt;
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    //----------------------------------------------------------------
    // pins and read value
    //----------------------------------------------------------------
    // drive only where direction is 1, inputs read the pin
    assign pin_out = data_r;
    assign pin_oe  = dir_r;
    assign rd_val  = (dir_r & data_r) | (~dir_r & sync2_r);

endmodule : pio_port

// ---- rtl/parallel_io_ports.sv ----
// parallel port block: bidirectional, input-only and open-drain ports
`include "pio_regs.svh"
module parallel_io_ports #(
    parameter int W0  = `PIO_W0,
    parameter int W1  = `PIO_W1,
    parameter int W2  = `PIO_W2,
    parameter int W3  = `PIO_W3,
    parameter int W4L = `PIO_W4L,
    parameter int W4H = `PIO_W4H,
    parameter int W5  = `PIO_W5,
    parameter int W6  = `PIO_W6
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    // cpu side
    input  wire pio_pkg::port_sel_t      cpu_sel,
    input  wire logic                    cpu_wr_data,
    input  wire logic                    cpu_wr_dir,
    input  wire logic [`PIO_BUS_W-1:0]   cpu_wdata,
    output logic      [`PIO_BUS_W-1:0]   cpu_rdata,
    // analog input enable for port 5
    input  wire logic [W5-1:0]           ana_en,
    // port 0
    input  wire logic [W0-1:0]           p0_in,
    output logic      [W0-1:0]           p0_out,
    output logic      [W0-1:0]           p0_oe,
    // port 1
    input  wire logic [W1-1:0]           p1_in,
    output logic      [W1-1:0]           p1_out,
    output logic      [W1-1:0]           p1_oe,
    // port 2
    input  wire logic [W2-1:0]           p2_in,
    output logic      [W2-1:0]           p2_out,
    output logic      [W2-1:0]           p2_oe,
    // port 3
    input  wire logic [W3-1:0]           p3_in,
    output logic      [W3-1:0]           p3_out,
    output logic      [W3-1:0]           p3_oe,
    // port 4
    input  wire logic [W4L+W4H-1:0]      p4_in,
    output logic      [W4L+W4H-1:0]      p4_out,
    output logic      [W4L+W4H-1:0]      p4_oe,
    // port 5
    input  wire logic [W5-1:0]           p5_in,
    output logic      [W5-1:0]           p5_out,
    output logic      [W5-1:0]           p5_oe,
    // port 6
    input  wire logic [W6-1:0]           p6_in,
    output logic      [W6-1:0]           p6_out,
    output logic      [W6-1:0]           p6_oe
);

    //----------------------------------------------------------------
    // internal signals
    //----------------------------------------------------------------
    // port read values, pin drive and storage
    logic [W0-1:0]         p0_rd;
    logic [W1-1:0]         p1_rd;
    logic [W2-1:0]         p2_rd;
    logic [W3-1:0]         p3_rd;
    logic [W4L-1:0]        p4l_rd;
    logic [W4L-1:0]        p4l_out;
    logic [W4L-1:0]        p4l_oe;
    logic [W6-1:0]         p6_rd;
    logic [W4H-1:0]        p4h_s1_r;
    logic [W4H-1:0]        p4h_s2_r;
    logic [W5-1:0]         p5_s1_r;
    logic [W5-1:0]         p5_s2_r;
    logic [W5-1:0]         p5_data_r;
    logic [W5-1:0]         p5_data_nxt;
    logic [W5-1:0]         p5_rd;
    logic [`PIO_BUS_W-1:0] rdata_r;
    logic [`PIO_BUS_W-1:0] rdata_nxt;

    // write strobes, one per register
    logic                  p0_wr_data;
    logic                  p0_wr_dir;
    logic                  p1_wr_data;
    logic                  p1_wr_dir;
    logic                  p2_wr_data;
    logic                  p2_wr_dir;
    logic                  p3_wr_data;
    logic                  p3_wr_dir;
    logic                  p4_wr_data;
    logic                  p4_wr_dir;
    logic                  p5_wr_data;
    logic                  p6_wr_data;
    logic                  p6_wr_dir;

    //----------------------------------------------------------------
    // write strobes
    //----------------------------------------------------------------
    // route the cpu strobes to the selected port only
    always_comb begin
        p0_wr_data = 1'b0;
        p0_wr_dir  = 1'b0;
        p1_wr_data = 1'b0;
        p1_wr_dir  = 1'b0;
        p2_wr_data = 1'b0;
        p2_wr_dir  = 1'b0;
        p3_wr_data = 1'b0;
        p3_wr_dir  = 1'b0;
        p4_wr_data = 1'b0;
        p4_wr_dir  = 1'b0;
        p5_wr_data = 1'b0;
        p6_wr_data = 1'b0;
        p6_wr_dir  = 1'b0;
        unique case (cpu_sel)
            pio_pkg::SEL_P0: begin
                p0_wr_data = cpu_wr_data;
                p0_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_P1: begin
                p1_wr_data = cpu_wr_data;
                p1_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_P2: begin
                p2_wr_data = cpu_wr_data;
                p2_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_P3: begin
                p3_wr_data = cpu_wr_data;
                p3_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_P4: begin
                p4_wr_data = cpu_wr_data;
                p4_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_P5: begin
                p5_wr_data = cpu_wr_data;
            end
            pio_pkg::SEL_P6: begin
                p6_wr_data = cpu_wr_data;
                p6_wr_dir  = cpu_wr_dir;
            end
            pio_pkg::SEL_NONE: begin
            end
        endcase
    end

    //----------------------------------------------------------------
    // bidirectional ports
    //----------------------------------------------------------------
    // port 0
    pio_port #(.W(W0)) u_p0 (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p0_wr_data),
        .wr_dir  (p0_wr_dir),
        .wdata   (cpu_wdata[W0-1:0]),
        .pin_in  (p0_in),
        .pin_out (p0_out),
        .pin_oe  (p0_oe),
        .rd_val  (p0_rd)
    );

    // port 1
    pio_port #(.W(W1)) u_p1 (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p1_wr_data),
        .wr_dir  (p1_wr_dir),
        .wdata   (cpu_wdata[W1-1:0]),
        .pin_in  (p1_in),
        .pin_out (p1_out),
        .pin_oe  (p1_oe),
        .rd_val  (p1_rd)
    );

    // port 2
    pio_port #(.W(W2)) u_p2 (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p2_wr_data),
        .wr_dir  (p2_wr_dir),
        .wdata   (cpu_wdata[W2-1:0]),
        .pin_in  (p2_in),
        .pin_out (p2_out),
        .pin_oe  (p2_oe),
        .rd_val  (p2_rd)
    );

    // port 3, only the low bits carry storage
    pio_port #(.W(W3)) u_p3 (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p3_wr_data),
        .wr_dir  (p3_wr_dir),
        .wdata   (cpu_wdata[W3-1:0]),
        .pin_in  (p3_in),
        .pin_out (p3_out),
        .pin_oe  (p3_oe),
        .rd_val  (p3_rd)
    );

    // port 4 low nibble
    pio_port #(.W(W4L)) u_p4l (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p4_wr_data),
        .wr_dir  (p4_wr_dir),
        .wdata   (cpu_wdata[W4L-1:0]),
        .pin_in  (p4_in[W4L-1:0]),
        .pin_out (p4l_out),
        .pin_oe  (p4l_oe),
        .rd_val  (p4l_rd)
    );

    // port 6, top bit absent
    pio_port #(.W(W6)) u_p6 (
        .clk     (clk),
        .srst    (srst),
        .wr_data (p6_wr_data),
        .wr_dir  (p6_wr_dir),
        .wdata   (cpu_wdata[W6-1:0]),
        .pin_in  (p6_in),
        .pin_out (p6_out),
        .pin_oe  (p6_oe),
        .rd_val  (p6_rd)
    );

    //----------------------------------------------------------------
    // port 4 high nibble: input only
    //----------------------------------------------------------------
    // two-flop synchroniser on the input-only pins
    always_ff @(posedge clk) begin
        if (srst) begin
            p4h_s1_r <= '0;
            p4h_s2_r <= '0;
        end else begin
            p4h_s1_r <= p4_in[W4L+W4H-1:W4L];
            p4h_s2_r <= p4h_s1_r;
        end
    end

    // never driven, no direction storage
    assign p4_out = {{W4H{1'b0}}, p4l_out};
    assign p4_oe  = {{W4H{1'b0}}, p4l_oe};

    //----------------------------------------------------------------
    // port 5: open drain, shared with analog inputs
    //----------------------------------------------------------------
    // data written by the cpu, direction writes ignored
    always_comb begin
        p5_data_nxt = p5_data_r;
        if (p5_wr_data) begin
            p5_data_nxt = cpu_wdata[W5-1:0];
        end
    end

    // register port 5 data and its pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            p5_data_r <= W5'(`PIO_DATA_RST);
            p5_s1_r   <= '0;
            p5_s2_r   <= '0;
        end else begin
            p5_data_r <= p5_data_nxt;
            p5_s1_r   <= p5_in;
            p5_s2_r   <= p5_s1_r;
        end
    end

    //----------------------------------------------------------------
    // port 5 pins and read value
    //----------------------------------------------------------------
    // pull low only on a 0, release otherwise or under analog use
    assign p5_out = '0;
    assign p5_oe  = ~p5_data_r & ~ana_en;
    assign p5_rd  = p5_s2_r & ~ana_en;

    //----------------------------------------------------------------
    // read path
    //----------------------------------------------------------------
    // select the addressed port, missing bits read as zero
    always_comb begin
        rdata_nxt = '0;
        unique case (cpu_sel)
            pio_pkg::SEL_P0:   rdata_nxt = `PIO_BUS_W'(p0_rd);
            pio_pkg::SEL_P1:   rdata_nxt = `PIO_BUS_W'(p1_rd);
            pio_pkg::SEL_P2:   rdata_nxt = `PIO_BUS_W'(p2_rd);
            pio_pkg::SEL_P3:   rdata_nxt = `PIO_BUS_W'(p3_rd);
            pio_pkg::SEL_P4:   rdata_nxt = `PIO_BUS_W'({p4h_s2_r, p4l_rd});
            pio_pkg::SEL_P5:   rdata_nxt = `PIO_BUS_W'(p5_rd);
            pio_pkg::SEL_P6:   rdata_nxt = `PIO_BUS_W'(p6_rd);
            pio_pkg::SEL_NONE: rdata_nxt = '0;
        endcase
    end

    // read data from a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign cpu_rdata = rdata_r;

endmodule : parallel_io_ports

// ---- tb/pin_board.sv ----
// board model: resolves every pin from block drive and outside level
module pin_board #(
    parameter logic [50:0] OD = '0
) (
    input  wire logic [50:0] oe,
    input  wire logic [50:0] out,
    input  wire logic [50:0] ext,
    output logic      [50:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven bits follow the block, open-drain bits only pull low
    always_comb begin
        for (int i = 0; i < 51; i++) begin
            lvl[i] = oe[i] ? (out[i] & ~OD[i]) : ext[i];
        end
    end
endmodule : pin_board

// ---- tb/parallel_io_ports_chk.sv ----
// assertion checker for the parallel port block
module parallel_io_ports_chk (
    input wire logic               clk,
    input wire logic               srst,
    input wire pio_pkg::port_sel_t cpu_sel,
    input wire logic               cpu_wr_data,
    input wire logic               cpu_wr_dir,
    input wire logic [15:0]        cpu_wdata,
    input wire logic [7:0]         ana_en,
    input wire logic [7:0]         p0_oe,
    input wire logic [3:0]         p1_oe,
    input wire logic [3:0]         p2_oe,
    input wire logic [11:0]        p3_oe,
    input wire logic [7:0]         p4_oe,
    input wire logic [7:0]         p5_oe,
    input wire logic [7:0]         p5_out,
    input wire logic [6:0]         p6_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    //----------------------------------------------------------------
    // direction writes, reset, input-only and open-drain pins
    //----------------------------------------------------------------
    sequence s_dir(pio_pkg::port_sel_t s);
        cpu_wr_dir && cpu_sel == s;
    endsequence
    property p_rst_in;
        $fell(srst) |-> (|{p0_oe, p1_oe, p2_oe, p3_oe, p4_oe, p6_oe}) == 1'b0;
    endproperty
    a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
    property p_p0_dir;
        s_dir(pio_pkg::SEL_P0) |=> p0_oe == $past(cpu_wdata[7:0]);
    endproperty
    a_p0_dir: assert property (p_p0_dir) else $error("port 0 enable wrong");
    property p_p3_dir;
        s_dir(pio_pkg::SEL_P3) |=> p3_oe == $past(cpu_wdata[11:0]);
    endproperty
    a_p3_dir: assert property (p_p3_dir) else $error("port 3 enable wrong");
    property p_p4_dir;
        s_dir(pio_pkg::SEL_P4) |=> p4_oe == {4'h0, $past(cpu_wdata[3:0])};
    endproperty
    a_p4_dir: assert property (p_p4_dir) else $error("port 4 enable wrong");
    property p_p4_in;
        p4_oe[7:4] == 4'h0;
    endproperty
    a_p4_in: assert property (p_p4_in) else $error("input-only bit driven");
    property p_p6_dir;
        s_dir(pio_pkg::SEL_P6) |=> p6_oe == $past(cpu_wdata[6:0]);
    endproperty
    a_p6_dir: assert property (p_p6_dir) else $error("port 6 enable wrong");
    property p_od;
        p5_out == 8'h00;
    endproperty
    a_od: assert property (p_od) else $error("open-drain bit drives high");
    property p_ana;
        (p5_oe & ana_en) == 8'h00;
    endproperty
    a_ana: assert property (p_ana) else $error("analog pin pulled low");
    property p_p5_dir;
        s_dir(pio_pkg::SEL_P5) ##0 !cpu_wr_data ##1 $stable(ana_en) |-> $stable(p5_oe);
    endproperty
    a_p5_dir: assert property (p_p5_dir) else $error("port 5 direction moved");
endmodule : parallel_io_ports_chk

// ---- tb/parallel_io_ports_test.sv ----
// self-checking bench for the parallel port block
module parallel_io_ports_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk         = 1'b0;
    logic               srst        = 1'b1;
    pio_pkg::port_sel_t cpu_sel     = pio_pkg::SEL_NONE;
    logic               cpu_wr_data = 1'b0;
    logic               cpu_wr_dir  = 1'b0;
    logic [15:0]        cpu_wdata   = 16'h0000;
    logic [15:0]        cpu_rdata;
    logic [7:0]         ana_en      = 8'h00;
    logic [50:0]        ext         = 51'h5A5C33C5A96E1;
    logic [50:0]        oe_all;
    logic [50:0]        out_all;
    logic [50:0]        lvl;
    int                 num_errors  = 0;
    int                 checks      = 0;
    int                 cyc         = 0;
    int                 lo [7]      = '{0, 8, 12, 16, 28, 36, 44};
    int                 wd [7]      = '{8, 4, 4, 12, 8, 8, 7};
    int                 bid [5]     = '{0, 1, 2, 3, 6};

    parallel_io_ports parallel_io_ports_i (
        .clk, .srst, .cpu_sel, .cpu_wr_data, .cpu_wr_dir, .cpu_wdata, .cpu_rdata, .ana_en,
        .p0_in(lvl[7:0]), .p0_out(out_all[7:0]), .p0_oe(oe_all[7:0]),
        .p1_in(lvl[11:8]), .p1_out(out_all[11:8]), .p1_oe(oe_all[11:8]),
        .p2_in(lvl[15:12]), .p2_out(out_all[15:12]), .p2_oe(oe_all[15:12]),
        .p3_in(lvl[27:16]), .p3_out(out_all[27:16]), .p3_oe(oe_all[27:16]),
        .p4_in(lvl[35:28]), .p4_out(out_all[35:28]), .p4_oe(oe_all[35:28]),
        .p5_in(lvl[43:36]), .p5_out(out_all[43:36]), .p5_oe(oe_all[43:36]),
        .p6_in(lvl[50:44]), .p6_out(out_all[50:44]), .p6_oe(oe_all[50:44])
    );
    pin_board #(.OD(51'h0FF000000000)) pin_board_i (.oe(oe_all), .out(out_all), .ext(ext), .lvl(lvl));

    // clock and cycle ceiling
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    function automatic logic [15:0] pv(input logic [50:0] v, input int s);
        return 16'((v >> lo[s]) & ((51'h1 << wd[s]) - 51'h1));
    endfunction : pv
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // whole-word writes only, never read-modify-write
    task automatic wr(input int s, input logic [15:0] d, input logic dat, input logic dir);
        @(negedge clk);
        cpu_sel = pio_pkg::port_sel_t'(s);
        cpu_wdata = d;
        cpu_wr_data = dat;
        cpu_wr_dir = dir;
        @(negedge clk);
        cpu_wr_data = 1'b0;
        cpu_wr_dir = 1'b0;
    endtask : wr
    task automatic rd(input int s, input logic [15:0] exp);
        @(negedge clk);
        cpu_sel = pio_pkg::port_sel_t'(s);
        repeat (4) @(negedge clk);
        cmp(cpu_rdata, exp);
    endtask : rd
    //----------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------
    task automatic t_reset();
        foreach (bid[i]) cmp(pv(oe_all, bid[i]), 16'h0000);
        cmp(pv(oe_all, 5), 16'h00FF);
    endtask : t_reset
    task automatic t_bidir();
        logic [15:0] m;
        foreach (bid[i]) begin
            m = pv(51'h7FFFFFFFFFFFF, bid[i]);
            wr(bid[i], 16'hFFFF, 1'b0, 1'b1);
            wr(bid[i], 16'hA5C3, 1'b1, 1'b0);
            cmp(pv(oe_all, bid[i]), m);
            cmp(pv(out_all, bid[i]), 16'hA5C3 & m);
            rd(bid[i], 16'hA5C3 & m);
            wr(bid[i], 16'h0000, 1'b0, 1'b1);
            cmp(pv(oe_all, bid[i]), 16'h0000);
            rd(bid[i], pv(ext, bid[i]));
        end
    endtask : t_bidir
    task automatic t_p4();
        wr(4, 16'hFFFF, 1'b1, 1'b1);
        cmp(pv(oe_all, 4), 16'h000F);
        cmp(pv(out_all, 4), 16'h000F);
        rd(4, (pv(ext, 4) & 16'h00F0) | 16'h000F);
    endtask : t_p4
    task automatic t_p5();
        ana_en = 8'hF0;
        wr(5, 16'h0000, 1'b1, 1'b0);
        cmp(pv(oe_all, 5), 16'h000F);
        wr(5, 16'hFFFF, 1'b0, 1'b1);
        cmp(pv(oe_all, 5), 16'h000F);
        wr(5, 16'h0005, 1'b1, 1'b0);
        cmp(pv(oe_all, 5), 16'h000A);
        cmp(pv(out_all, 5), 16'h0000);
        rd(5, pv(ext, 5) & 16'h0005);
    endtask : t_p5
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_bidir();
        t_p4();
        t_p5();
        print_verdict();
    end
endmodule : parallel_io_ports_test

bind parallel_io_ports parallel_io_ports_chk chk_i (.clk, .srst, .cpu_sel, .cpu_wr_data, .cpu_wr_dir, .cpu_wdata,
    .ana_en, .p0_oe, .p1_oe, .p2_oe, .p3_oe, .p4_oe, .p5_oe, .p5_out, .p6_oe);
